// file: rbc_ctrl.sv
// Reversal backlash compensation controller for the position loop
//
// Overview of operation
// - A sign change of the increment triggers the reversal-peak pulse.
// - The pulse is held off by a delay in ms, default zero.
// - The delay becomes whole loop periods, rounded down.
// - The pulse stops once feedback travel reaches the cancel displacement.
// - Cancel displacement zero or minus one unit disables early cancel.
// - Cancel displacement resets to zero.
// - With cancel displacement zero or more, friction is off in a reversal.
// - A later reversal compensates only after command moves the hysteresis.
// - Reversals inside the hysteresis run without compensation.
// - Once reached, compensate and take the next reversal as reference.
// - Hysteresis zero compensates every reversal.
// - Friction compensation is off while the pulse is active.
// - Friction switching uses a programmable speed hysteresis in rpm.
// - The pulse starts at the amplitude and decays with the time constant.
// - Compensation only in position mode with direct feedback.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module rbc_ctrl
   import rbc_pkg::*;
#(
   parameter int LOOP_US_P = LOOP_US
)
(
   input  wire logic             clk,       // 25 MHz clock
   input  wire logic             srst,      // Synchronous reset, high
   input  wire rbc_loop_s        loop_in,   // Per-cycle increments and speed
   input  wire logic [3:0]       addr,      // Register address
   input  wire logic [31:0]      wdata,     // Write data
   input  wire logic             wr,        // Write strobe
   input  wire logic             rd,        // Read strobe
   output rbc_comp_s             comp_out,  // Compensation outputs
   output logic      [31:0]      rdata      // Read data, one cycle later
);
   initial
   begin
      if (LOOP_US_P < 1)
         $error("loop period must be positive");
   end

   // Registers
   logic [31:0] ctrl_reg;
   logic [31:0] delay_ms_reg;
   logic [31:0] cancel_reg;
   logic [31:0] hyst_reg;
   logic [31:0] ampl_reg;
   logic [31:0] tau_reg;
   logic [31:0] fric_hyst_reg;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_reg      <= RST_CTRL;
         delay_ms_reg  <= RST_DELAY_MS;
         cancel_reg    <= RST_CANCEL;
         hyst_reg      <= RST_HYST;
         ampl_reg      <= RST_AMPL;
         tau_reg       <= RST_TAU_MS;
         fric_hyst_reg <= RST_FRIC_HYST;
      end
      else if (wr)
      begin
         case (addr)
            ADDR_CTRL:      ctrl_reg      <= wdata;
            ADDR_DELAY_MS:  delay_ms_reg  <= wdata;
            ADDR_CANCEL:    cancel_reg    <= wdata;
            ADDR_HYST:      hyst_reg      <= wdata;
            ADDR_AMPL:      ampl_reg      <= wdata;
            ADDR_TAU_MS:    tau_reg       <= wdata;
            ADDR_FRIC_HYST: fric_hyst_reg <= wdata;
            default:        ;
         endcase
      end
   end

   // Helpers
   function automatic logic [POS_W-1:0] abs_val(input logic [POS_W-1:0] v);
      abs_val = v[POS_W-1] ? POS_W'(-v) : v;
   endfunction

   logic [DLY_W-1:0] delay_loops;
   logic [VEL_W-1:0] decay_next;
   logic [VEL_W-1:0] pulse_reg;

   rbc_ms_to_loops #(.LOOP_US_P(LOOP_US_P)) u_conv
   (
      .delay_ms (delay_ms_reg[DLY_W-1:0]),
      .loops    (delay_loops)
   );

   rbc_decay u_decay
   (
      .value      (pulse_reg),
      .tau_ms     (tau_reg[DLY_W-1:0]),
      .next_value (decay_next)
   );

   // Reversal detection
   logic              tick;
   logic              enabled;
   logic              last_sign_reg;
   logic              have_dir_reg;
   logic              cmd_nz;
   logic              cmd_sign;
   logic              reversal;
   logic [POS_W-1:0]  cmd_acc_reg;
   logic              armed_reg;
   logic              comp_req;

   assign tick     = loop_in.valid;
   assign enabled  = ctrl_reg[CTRL_POS_MODE] & ctrl_reg[CTRL_DIRECT];
   assign cmd_nz   = loop_in.cmd_inc != '0;
   assign cmd_sign = loop_in.cmd_inc[POS_W-1];
   // Sign opposite to the last nonzero increment
   assign reversal = tick & cmd_nz & have_dir_reg & (cmd_sign != last_sign_reg);
   // First reversal, or hysteresis already met, or hysteresis zero
   assign comp_req = reversal & enabled & (armed_reg | (hyst_reg == '0));

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         last_sign_reg <= 1'b0;
         have_dir_reg  <= 1'b0;
      end
      else if (tick && cmd_nz)
      begin
         last_sign_reg <= cmd_sign;
         have_dir_reg  <= 1'b1;
      end
   end

   // Command change since the reference reversal
   logic [POS_W-1:0] cmd_acc_next;
   assign cmd_acc_next = POS_W'(cmd_acc_reg + loop_in.cmd_inc);

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cmd_acc_reg <= '0;
         armed_reg   <= 1'b1;
      end
      else if (tick)
      begin
         if (comp_req)
         begin
            cmd_acc_reg <= '0;
            armed_reg   <= 1'b0;
         end
         else
         begin
            cmd_acc_reg <= cmd_acc_next;
            if (abs_val(cmd_acc_next) >= hyst_reg)
               armed_reg <= 1'b1;
         end
      end
   end

   // Pulse sequencer
   rbc_state_e        state_reg;
   logic [DLY_W-1:0]  dly_cnt_reg;
   logic [POS_W-1:0]  disp_acc_reg;
   logic [POS_W-1:0]  disp_next;
   logic              cancel_on;
   logic              cancel_hit;

   assign disp_next  = POS_W'(disp_acc_reg + loop_in.fb_inc);
   assign cancel_on  = (cancel_reg != '0) && (cancel_reg != CANCEL_LEGACY) &&
                       !cancel_reg[31];
   assign cancel_hit = cancel_on && (abs_val(disp_next) >= cancel_reg);

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_reg    <= RBC_IDLE;
         dly_cnt_reg  <= '0;
         pulse_reg    <= '0;
         disp_acc_reg <= '0;
      end
      else if (tick)
      begin
         if (comp_req)
         begin
            disp_acc_reg <= loop_in.fb_inc;
            if (delay_loops == '0)
            begin
               state_reg <= RBC_PULSE;
               pulse_reg <= ampl_reg[VEL_W-1:0];
            end
            else
            begin
               state_reg   <= RBC_DELAY;
               dly_cnt_reg <= delay_loops;
               pulse_reg   <= '0;
            end
         end
         else
         begin
            case (state_reg)
               RBC_IDLE:
               begin
                  pulse_reg <= '0;
               end
               RBC_DELAY:
               begin
                  disp_acc_reg <= disp_next;
                  if (dly_cnt_reg == DLY_W'(1))
                  begin
                     state_reg <= RBC_PULSE;
                     pulse_reg <= ampl_reg[VEL_W-1:0];
                  end
                  dly_cnt_reg <= dly_cnt_reg - DLY_W'(1);
               end
               RBC_PULSE:
               begin
                  disp_acc_reg <= disp_next;
                  if (cancel_hit || decay_next == '0)
                  begin
                     state_reg <= RBC_IDLE;
                     pulse_reg <= '0;
                  end
                  else
                     pulse_reg <= decay_next;
               end
               default:
               begin
                  state_reg <= RBC_IDLE;
                  pulse_reg <= '0;
               end
            endcase
         end
      end
   end

   // Friction switching with speed hysteresis
   logic             fric_dir_reg;
   logic [VEL_W-1:0] speed_mag;
   logic             in_reversal;

   assign speed_mag   = loop_in.speed[VEL_W-1] ? VEL_W'(-loop_in.speed) : loop_in.speed;
   assign in_reversal = (state_reg != RBC_IDLE);

   always_ff @(posedge clk)
   begin
      if (srst)
         fric_dir_reg <= 1'b0;
      else if (tick && speed_mag >= fric_hyst_reg[VEL_W-1:0])
         fric_dir_reg <= loop_in.speed[VEL_W-1];
   end

   // Outputs
   always_ff @(posedge clk)
   begin
      if (srst)
         comp_out <= '0;
      else
      begin
         comp_out.active  <= (state_reg == RBC_PULSE);
         comp_out.vel_add <= (state_reg == RBC_PULSE) ? pulse_reg : '0;
         comp_out.fric_en <= !(in_reversal && !cancel_reg[31]) &&
                             (state_reg != RBC_PULSE);
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         rdata <= '0;
      else if (rd)
      begin
         case (addr)
            ADDR_CTRL:      rdata <= ctrl_reg;
            ADDR_DELAY_MS:  rdata <= delay_ms_reg;
            ADDR_CANCEL:    rdata <= cancel_reg;
            ADDR_HYST:      rdata <= hyst_reg;
            ADDR_AMPL:      rdata <= ampl_reg;
            ADDR_TAU_MS:    rdata <= tau_reg;
            ADDR_FRIC_HYST: rdata <= fric_hyst_reg;
            ADDR_STATUS:    rdata <= {28'h0000000, fric_dir_reg, comp_out.fric_en,
                                      state_reg == RBC_DELAY, state_reg == RBC_PULSE};
            ADDR_VEL_OUT:   rdata <= {{(32-VEL_W){1'b0}}, pulse_reg};
            default:        rdata <= 32'h0000_0000;
         endcase
      end
      else
         rdata <= 32'h0000_0000;
   end

   // Checks
   chk_rev_comp_start: assert property (@(posedge clk) disable iff (srst)
      comp_req && delay_loops == '0 |=> state_reg == RBC_PULSE)
      else $error("pulse did not start on reversal");
   chk_delay_hold: assert property (@(posedge clk) disable iff (srst)
      comp_req && delay_loops != '0 |=> state_reg == RBC_DELAY)
      else $error("delay not applied");
   chk_cancel_stop: assert property (@(posedge clk) disable iff (srst)
      tick && state_reg == RBC_PULSE && cancel_hit && !comp_req |=> state_reg == RBC_IDLE)
      else $error("pulse not cancelled");
   chk_no_cancel: assert property (@(posedge clk) disable iff (srst)
      !cancel_on |-> !cancel_hit)
      else $error("early cancel while disabled");
   chk_fric_off: assert property (@(posedge clk) disable iff (srst)
      state_reg == RBC_PULSE |=> !comp_out.fric_en)
      else $error("friction on during pulse");
   chk_hyst_block: assert property (@(posedge clk) disable iff (srst)
      reversal && !armed_reg && hyst_reg != '0 |=> state_reg == $past(state_reg) ||
      $past(state_reg) != RBC_IDLE)
      else $error("compensation inside hysteresis");
   chk_mode_gate: assert property (@(posedge clk) disable iff (srst)
      !enabled |-> !comp_req)
      else $error("compensation outside direct position mode");
   chk_tick_only: assert property (@(posedge clk) disable iff (srst)
      !tick |=> $stable(pulse_reg))
      else $error("pulse moved without loop tick");
   chk_pulse_out: assert property (@(posedge clk) disable iff (srst)
      state_reg != RBC_PULSE |=> comp_out.vel_add == '0)
      else $error("velocity added while idle");
   chk_fric_rev: assert property (@(posedge clk) disable iff (srst)
      state_reg != RBC_IDLE && !cancel_reg[31] |=> !comp_out.fric_en)
      else $error("friction on during reversal");
   chk_armed_clear: assert property (@(posedge clk) disable iff (srst)
      comp_req |=> !armed_reg)
      else $error("hysteresis reference not restarted");
   chk_disp_start: assert property (@(posedge clk) disable iff (srst)
      comp_req |=> disp_acc_reg == $past(loop_in.fb_inc))
      else $error("displacement not restarted at reversal");
   chk_delay_load: assert property (@(posedge clk) disable iff (srst)
      comp_req && delay_loops != '0 |=> dly_cnt_reg == $past(delay_loops))
      else $error("delay count not loaded");

   cov_rev: cover property (@(posedge clk) disable iff (srst) comp_req);
   cov_delay: cover property (@(posedge clk) disable iff (srst) state_reg == RBC_DELAY);
   cov_cancel: cover property (@(posedge clk) disable iff (srst)
      state_reg == RBC_PULSE && cancel_hit);
   cov_blocked: cover property (@(posedge clk) disable iff (srst) reversal && !comp_req);
   cov_rearm: cover property (@(posedge clk) disable iff (srst) !armed_reg ##1 armed_reg);
endmodule

// file: rbc_pkg.sv
// Package for the reversal backlash compensation controller
package rbc_pkg;
   localparam int POS_W      = 32;
   localparam int VEL_W      = 24;
   localparam int DLY_W      = 16;
   localparam int CLK_HZ     = 25000000;
   localparam int LOOP_US    = 1000;
   localparam int CLK_PER_LOOP = (CLK_HZ / 1000000) * LOOP_US;
   // Offsets of the register port
   localparam logic [3:0] ADDR_CTRL      = 4'h0;
   localparam logic [3:0] ADDR_DELAY_MS  = 4'h1;
   localparam logic [3:0] ADDR_CANCEL    = 4'h2;
   localparam logic [3:0] ADDR_HYST      = 4'h3;
   localparam logic [3:0] ADDR_AMPL      = 4'h4;
   localparam logic [3:0] ADDR_TAU_MS    = 4'h5;
   localparam logic [3:0] ADDR_FRIC_HYST = 4'h6;
   localparam logic [3:0] ADDR_STATUS    = 4'h7;
   localparam logic [3:0] ADDR_VEL_OUT   = 4'h8;
   // Field positions
   localparam int CTRL_POS_MODE = 0;
   localparam int CTRL_DIRECT   = 1;
   localparam int ST_ACTIVE     = 0;
   localparam int ST_WAITING    = 1;
   localparam int ST_FRIC_EN    = 2;
   localparam int ST_SIGN       = 3;
   // Reset values
   localparam logic [31:0] RST_CTRL      = 32'h0000_0003;
   localparam logic [31:0] RST_DELAY_MS  = 32'h0000_0000;
   localparam logic [31:0] RST_CANCEL    = 32'h0000_0000;
   localparam logic [31:0] RST_HYST      = 32'h0000_0000;
   localparam logic [31:0] RST_AMPL      = 32'h0000_0000;
   localparam logic [31:0] RST_TAU_MS    = 32'h0000_001E;
   localparam logic [31:0] RST_FRIC_HYST = 32'h0000_0001;
   // Minus one unit of 0.0001 disables the early cancel, like zero
   localparam logic [31:0] CANCEL_LEGACY = 32'hFFFF_FFFF;

   typedef struct packed {
      logic              valid;
      logic [POS_W-1:0]  cmd_inc;
      logic [POS_W-1:0]  fb_inc;
      logic [VEL_W-1:0]  speed;
   } rbc_loop_s;

   typedef struct packed {
      logic              active;
      logic              fric_en;
      logic [VEL_W-1:0]  vel_add;
   } rbc_comp_s;

   typedef enum logic [1:0] { RBC_IDLE, RBC_DELAY, RBC_PULSE } rbc_state_e;
endpackage

// file: rbc_ms_to_loops.sv
// Converts a delay in milliseconds to whole loop periods, rounded down
`timescale 1ns/1ps
module rbc_ms_to_loops
   import rbc_pkg::*;
#(
   parameter int LOOP_US_P = LOOP_US
)
(
   input  wire logic [DLY_W-1:0] delay_ms,   // Programmed delay
   output logic      [DLY_W-1:0] loops       // Whole loop periods
);
   initial
   begin
      if (LOOP_US_P < 1)
         $error("loop period must be positive");
   end

   logic [DLY_W+10-1:0] us_val;

   always_comb
   begin
      us_val = delay_ms * (DLY_W+10)'(1000);
      loops  = DLY_W'(us_val / (DLY_W+10)'(LOOP_US_P));
   end
endmodule

// file: rbc_decay.sv
// Exponential decay step for the reversal pulse
`timescale 1ns/1ps
module rbc_decay
   import rbc_pkg::*;
(
   input  wire logic [VEL_W-1:0] value,      // Present pulse value
   input  wire logic [DLY_W-1:0] tau_ms,     // Time constant in ms
   output logic      [VEL_W-1:0] next_value  // Value one loop later
);
   // One loop step of 1 ms: v - v/(tau) approximates v*exp(-T/tau)
   logic [VEL_W-1:0] dec;

   always_comb
   begin
      if (tau_ms == '0)
         dec = value;
      else
      begin
         dec = value / VEL_W'(tau_ms);
         if (dec == '0 && value != '0)
            dec = VEL_W'(1);
      end
      next_value = value - dec;
   end
endmodule

// file: rbc_cnc_model.sv
// Model of the numeric controller that sends one increment pair per loop tick
`timescale 1ns/1ps
module rbc_cnc_model
   import rbc_pkg::*;
#(
   parameter int LAT = 2
)
(
   input  wire logic             clk,   // Clock
   input  wire logic             srst,  // Synchronous reset
   input  wire logic             send,  // Tick request, held until valid
   input  wire logic [POS_W-1:0] cmd,   // Command increment to send
   input  wire logic [POS_W-1:0] fb,    // Feedback increment to send
   output rbc_loop_s             loop   // Loop stream into the drive
);
   logic [3:0] cnt_reg;
   logic       busy_reg;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         busy_reg <= 1'b0;
         cnt_reg  <= 4'h0;
         loop     <= '0;
      end
      else if (loop.valid)
      begin
         // Off the tick the fields show inverted stale data, and valid drops
         loop     <= ~loop;
         busy_reg <= 1'b0;
      end
      else if (send && !busy_reg)
      begin
         busy_reg <= 1'b1;
         cnt_reg  <= LAT[3:0];
      end
      else if (busy_reg && cnt_reg != 4'h0)
         cnt_reg <= cnt_reg - 4'h1;
      else if (busy_reg)
         // Speed takes the low command bits, so its sign follows the move
         loop <= {1'b1, cmd, fb, cmd[VEL_W-1:0]};
   end
endmodule

// file: rbc_ctrl_bench.sv
// Self-checking bench for the reversal compensation controller
`timescale 1ns/1ps
module rbc_ctrl_bench
   import rbc_pkg::*;
;
   localparam logic [31:0] P2 = 32'h0000_0002;
   localparam logic [31:0] N2 = 32'hFFFF_FFFE;
   localparam logic [31:0] P3 = 32'h0000_0003;
   localparam logic [31:0] N3 = 32'hFFFF_FFFD;
   localparam logic [31:0] AMP = 32'h0000_0064;
   localparam logic [31:0] RV [0:6] = '{RST_CTRL, RST_DELAY_MS, RST_CANCEL, RST_HYST,
                                        RST_AMPL, RST_TAU_MS, RST_FRIC_HYST};
   localparam logic [31:0] CV [0:2] = '{32'h0000_0005, CANCEL_LEGACY, 32'h0000_0000};
   localparam logic        CA [0:2] = '{1'b0, 1'b1, 1'b1};

   logic             clk       = 1'b0;
   logic             srst      = 1'b1;
   logic             send      = 1'b0;
   logic [POS_W-1:0] cmd       = '0;
   logic [POS_W-1:0] fb        = '0;
   logic [3:0]       addr      = 4'h0;
   logic [31:0]      wdata     = 32'h0;
   logic             wr        = 1'b0;
   logic             rd        = 1'b0;
   rbc_loop_s        loop_in;
   rbc_comp_s        comp_out;
   logic [31:0]      rdata;
   int               bad_count = 0;
   int               checks    = 0;
   int               cyc       = 0;

   always #20 clk = ~clk;

   rbc_cnc_model CNC (.clk(clk), .srst(srst), .send(send), .cmd(cmd), .fb(fb), .loop(loop_in));

   rbc_ctrl #(.LOOP_US_P(400)) DUT (.clk(clk), .srst(srst), .loop_in(loop_in), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .comp_out(comp_out), .rdata(rdata));

   task automatic conclude();
      if (bad_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic act(input logic e);
      chk({31'h0, comp_out.active}, {31'h0, e});
   endtask

   task automatic vel(input logic [31:0] v);
      chk({8'h00, comp_out.vel_add}, v);
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   // One loop tick; returns once the compensation output has followed it
   task automatic tick(input logic [31:0] c, input logic [31:0] f);
      @(posedge clk);
      send <= 1'b1;
      cmd  <= c;
      fb   <= f;
      do
         @(posedge clk);
      while (loop_in.valid !== 1'b1);
      send <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic rst();
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      #1;
      chk({6'h00, comp_out}, 32'h0);
   endtask

   // Reversals with either mode bit off must not compensate, ending moving negative
   task automatic prime();
      for (int i = 0; i < 3; i++)
      begin
         wr_reg(ADDR_CTRL, i);
         tick(P2, 32'h1);
         tick(N2, 32'hFFFF_FFFF);
         act(1'b0);
      end
      wr_reg(ADDR_CTRL, RST_CTRL);
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 7; i++)
         rd_chk(i[3:0], RV[i]);
      rd_chk(4'h9, 32'h0);
      wr_reg(4'h9, 32'hFFFF_FFFF);
      rd_chk(4'h9, 32'h0);
      wr_reg(ADDR_CANCEL, 32'h0000_0005);
      rd_chk(ADDR_CANCEL, 32'h0000_0005);
      // Plain reversal, decay, and an immediate second reversal
      rst();
      wr_reg(ADDR_AMPL, AMP);
      prime();
      tick(P2, 32'h1);
      act(1'b1);
      vel(AMP);
      chk({31'h0, comp_out.fric_en}, 32'h0);
      repeat (3) @(posedge clk);
      #1;
      vel(AMP);
      tick(P2, 32'h1);
      vel(32'h0000_0061);
      tick(N2, 32'hFFFF_FFFF);
      vel(AMP);
      // Early cancel by absolute feedback travel, and the two disabled settings
      for (int k = 0; k < 3; k++)
      begin
         rst();
         wr_reg(ADDR_AMPL, AMP);
         wr_reg(ADDR_CANCEL, CV[k]);
         prime();
         tick(P2, N3);
         act(1'b1);
         tick(P2, N3);
         tick(P2, N3);
         act(CA[k]);
      end
      // Delay of 1 ms at a 400 us loop truncates to two ticks
      rst();
      wr_reg(ADDR_AMPL, AMP);
      wr_reg(ADDR_DELAY_MS, 32'h0000_0001);
      prime();
      tick(P2, 32'h1);
      act(1'b0);
      chk({31'h0, comp_out.fric_en}, 32'h0);
      tick(P2, 32'h1);
      act(1'b0);
      tick(P2, 32'h1);
      act(1'b1);
      vel(AMP);
      // Reversal hysteresis of ten units of command travel
      rst();
      wr_reg(ADDR_AMPL, AMP);
      wr_reg(ADDR_CANCEL, 32'h0000_0004);
      prime();
      tick(P2, P3);
      act(1'b1);
      wr_reg(ADDR_HYST, 32'h0000_000A);
      tick(P2, P3);
      tick(N2, N3);
      act(1'b0);
      repeat (7) tick(N2, N3);
      tick(P2, P3);
      act(1'b1);
      tick(N2, N3);
      vel(32'h0000_0061);
      // Friction direction follows speed only once its magnitude reaches the hysteresis
      rst();
      wr_reg(ADDR_CTRL, 32'h0000_0000);
      tick(N2, 32'h0);
      rd_chk(ADDR_STATUS, 32'h0000_000C);
      wr_reg(ADDR_FRIC_HYST, P3);
      tick(P2, 32'h0);
      rd_chk(ADDR_STATUS, 32'h0000_000C);
      tick(P3, 32'h0);
      rd_chk(ADDR_STATUS, 32'h0000_0004);
      conclude();
   end
endmodule
